/* File: pkg/uie_regs.vh */
// Bit positions, reset values and sizes for the IN endpoint control block.
// Assumes inclusion by plain Verilog-2005 design files only.
`ifndef UIE_REGS_VH
`define UIE_REGS_VH
`define UIE_LOW_PKT_READY   0
`define UIE_LOW_FIFO_NE     1
`define UIE_LOW_UNDERRUN    2
`define UIE_LOW_FLUSH       3
`define UIE_LOW_SEND_STALL  4
`define UIE_LOW_SENT_STALL  5
`define UIE_LOW_CLR_TOGGLE  6
`define UIE_HIGH_DBUF       7
`define UIE_HIGH_ISO        6
`define UIE_HIGH_DIR_SEL    5
`define UIE_HIGH_FORCE_TGL  3
`define UIE_HIGH_SPLIT      2
`define UIE_CTRL_RESET      8'h00
`define UIE_FIFO_DEPTH      8
`define UIE_FIFO_WIDTH      9
`endif

/* File: core/uie_fifo.v */
// Byte FIFO for one IN endpoint; each word is {last, data}.
// Assumes one clock; clear empties it at once and wins over a push.
`timescale 1ns/1ps
module uie_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             clear,
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   output wire             outValid,
   input  wire             outReady,
   output reg  [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wrPtr;
   reg [AW-1:0]    rdPtr;
   reg [AW:0]      count;
   reg             headValid;
   wire            push;
   wire            load;

   // The head word sits in a register so the reader sees flop outputs.
   // It still takes one of the DEPTH places, so the FIFO never holds more than DEPTH words.
   assign inReady  = ((count + {{AW{1'b0}}, headValid}) < DEPTH);
   assign outValid = headValid;
   assign push     = inValid && inReady;
   assign load     = (count != 0) && (!headValid || outReady);

   always @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr     <= {AW{1'b0}};
         rdPtr     <= {AW{1'b0}};
         count     <= {(AW+1){1'b0}};
         headValid <= 1'b0;
         outData   <= {WIDTH{1'b0}};
      end else if (clear) begin
         wrPtr     <= {AW{1'b0}};
         rdPtr     <= {AW{1'b0}};
         count     <= {(AW+1){1'b0}};
         headValid <= 1'b0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == DEPTH - 1) ? {AW{1'b0}} : wrPtr + 1'b1;
         end
         if (load) begin
            outData   <= mem[rdPtr];
            headValid <= 1'b1;
            rdPtr     <= (rdPtr == DEPTH - 1) ? {AW{1'b0}} : rdPtr + 1'b1;
         end else if (outReady) begin
            headValid <= 1'b0;
         end
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      end
   end
endmodule

/* File: core/uie_view.v */
// Read-back selector: shows one endpoint's control bytes chosen by the index.
// Assumes packed inputs, endpoint 1 in the low byte; index 0 reads as zero.
`timescale 1ns/1ps
`include "uie_regs.vh"
module uie_view (
   input  wire        clk,
   input  wire        rst,
   input  wire [1:0]  index,
   input  wire [23:0] lowAll,
   input  wire [23:0] highAll,
   output reg  [7:0]  lowOut,
   output reg  [7:0]  highOut
);
   function [7:0] pickByte;
      input [23:0] all;
      input [1:0]  idx;
      begin
         case (idx)
            2'h1:    pickByte = all[7:0];
            2'h2:    pickByte = all[15:8];
            2'h3:    pickByte = all[23:16];
            default: pickByte = 8'h00;
         endcase
      end
   endfunction

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lowOut  <= `UIE_CTRL_RESET;
         highOut <= `UIE_CTRL_RESET;
      end else begin
         lowOut  <= pickByte(lowAll, index);
         highOut <= pickByte(highAll, index);
      end
   end
endmodule

/* File: core/uie_in_ctrl.v */
// IN side control for endpoints 1 to 3: control bits, packet slots, token answers.
// Assumes a packet engine that serialises tx* and reports host handshakes.
//
// How it works
// - Read-back shows only the endpoint chosen by the index.
// - Split mode set gives the endpoint both IN and OUT pipes.
// - Split clear: direction select picks IN or OUT alone.
// - High control bit 6 selects isochronous; clear means bulk/interrupt.
// - Bulk and interrupt IN share one identical behaviour.
// - Interrupt on sent packet, flush of non-empty FIFO, or STALL.
// - IN token with packet ready sends it, clears ready, interrupts.
// - Ready set with no bytes loaded sends a zero-length packet.
// - Send-stall set answers every bulk/interrupt IN with STALL.
// - Each STALL interrupts and sets sent-stall; firmware clears it.
// - Packet ready clears itself whenever a packet slot is free.
// - Double buffered: first load clears ready without an interrupt.
// - Force toggle flips data toggle after every bulk/interrupt packet.
// - Without force, toggle flips only on host ACK.
// - Isochronous token with nothing ready sends zero-length, sets underrun.
// - Iso update holds newly loaded packets until next start-of-frame.
`timescale 1ns/1ps
`include "uie_regs.vh"
module uie_in_ctrl #(
   parameter DEPTH = `UIE_FIFO_DEPTH
) (
   input  wire       clk,
   input  wire       rst,
   input  wire [1:0] fwIndex,
   input  wire       fwLowWr,
   input  wire       fwHighWr,
   input  wire [7:0] fwWrData,
   output wire [7:0] fwLowRd,
   output wire [7:0] fwHighRd,
   input  wire       fwDataValid,
   input  wire [7:0] fwData,
   input  wire       fwDataLast,
   output wire       fwDataReady,
   input  wire       isoUpdate,
   input  wire       sof,
   input  wire       tokenIn,
   input  wire [1:0] tokenEp,
   input  wire       hostAck,
   input  wire       hostTimeout,
   output reg        txStart,
   output reg        txZeroLen,
   output reg        txStall,
   output reg        txNak,
   output reg        txToggle,
   output wire       txValid,
   output wire [7:0] txData,
   output wire       txLast,
   input  wire       txReady,
   output reg  [2:0] epInIrq,
   output wire [2:0] epInEnabled,
   output wire [2:0] epOutEnabled
);
   localparam S_IDLE = 2'h0;
   localparam S_SEND = 2'h1;
   localparam S_HS   = 2'h2;

   reg  [1:0]  state;
   reg  [1:0]  curEp;
   reg  [3:1]  dbuf, iso, direction_select, forceTgl, split;
   reg  [3:1]  pktReady, sendStall, sentStall, underrun, toggle, pending;
   reg  [1:0]  pktCnt [1:3];
   reg  [1:0]  held   [1:3];
   reg  [1:0]  zq     [1:3];
   reg  [1:0]  next_pktCnt [1:3];
   reg  [1:0]  next_held   [1:3];
   reg  [1:0]  next_zq     [1:3];
   reg  [3:1]  next_pktReady, next_sentStall, next_underrun, next_toggle, next_pending;
   reg  [3:1]  next_irq;
   reg  [3:1]  commit, flush, done, stallEvt, underEvt;
   reg  [1:0]  pos;
   wire [27:1] fifoOut;
   wire [3:1]  fifoOutValid, fifoInReady, fifoPush, fifoPop;
   wire [23:0] lowAll, highAll;
   wire [8:0]  curWord;
   wire        tokOk;
   wire        avail;
   integer     e;
   integer     k;
   integer     r;

   function [1:0] slotsOf;
      input db;
      begin
         slotsOf = db ? 2'h2 : 2'h1;
      end
   endfunction

   function [8:0] pickWord;
      input [26:0] all;
      input [1:0]  ep;
      begin
         case (ep)
            2'h1:    pickWord = all[8:0];
            2'h2:    pickWord = all[17:9];
            2'h3:    pickWord = all[26:18];
            default: pickWord = 9'h000;
         endcase
      end
   endfunction

   genvar g;
   generate
      for (g = 1; g <= 3; g = g + 1) begin : ep
         assign fifoPush[g] = fwDataValid && (fwIndex == g) && fifoInReady[g];
         assign fifoPop[g]  = txReady && (state == S_SEND) && (curEp == g);
         uie_fifo #(
            .WIDTH (`UIE_FIFO_WIDTH),
            .DEPTH (DEPTH),
            .AW    (3)
         ) u_fifo (
            .clk      (clk),
            .rst      (rst),
            .clear    (flush[g]),
            .inValid  (fwDataValid && (fwIndex == g)),
            .inReady  (fifoInReady[g]),
            .inData   ({fwDataLast, fwData}),
            .outValid (fifoOutValid[g]),
            .outReady (fifoPop[g]),
            .outData  (fifoOut[g*9 -: 9])
         );
         assign lowAll[g*8-1 -: 8]  = {2'b00, sentStall[g], sendStall[g], 1'b0, underrun[g],
                                       (pktCnt[g] != 2'h0), pktReady[g]};
         assign highAll[g*8-1 -: 8] = {dbuf[g], iso[g], direction_select[g], 1'b0, forceTgl[g], split[g], 2'b00};
         assign epInEnabled[g-1]  = split[g] | direction_select[g];
         assign epOutEnabled[g-1] = split[g] | ~direction_select[g];
      end
   endgenerate

   uie_view u_view (
      .clk     (clk),
      .rst     (rst),
      .index   (fwIndex),
      .lowAll  (lowAll),
      .highAll (highAll),
      .lowOut  (fwLowRd),
      .highOut (fwHighRd)
   );

   assign fwDataReady = (fwIndex != 2'h0) && fifoInReady[fwIndex];
   assign curWord     = pickWord(fifoOut, curEp);
   assign txValid     = (state == S_SEND) && fifoOutValid[curEp];
   assign txData      = curWord[7:0];
   assign txLast      = curWord[8];
   assign tokOk       = tokenIn && (tokenEp != 2'h0) && epInEnabled[tokenEp - 2'h1];
   // Withheld packets are the newest ones, so only the older ones may go out.
   assign avail       = (pktCnt[tokenEp] > held[tokenEp]);

   // Events seen by the per-endpoint bookkeeping below.
   always @* begin
      commit   = 3'b000;
      flush    = 3'b000;
      done     = 3'b000;
      stallEvt = 3'b000;
      underEvt = 3'b000;
      for (k = 1; k <= 3; k = k + 1) begin
         commit[k] = fwLowWr && (fwIndex == k) && fwWrData[`UIE_LOW_PKT_READY];
         flush[k]  = fwLowWr && (fwIndex == k) && fwWrData[`UIE_LOW_FLUSH];
         if (state == S_HS && curEp == k && (iso[k] || hostAck || hostTimeout)) begin
            done[k] = 1'b1;
         end
         if (state == S_IDLE && tokOk && tokenEp == k) begin
            stallEvt[k] = sendStall[k] && !iso[k];
            underEvt[k] = !(sendStall[k] && !iso[k]) && !avail;
         end
      end
   end

   always @* begin
      pos = 2'h0;
      for (e = 1; e <= 3; e = e + 1) begin
         next_pktCnt[e]    = pktCnt[e];
         next_held[e]      = held[e];
         next_zq[e]        = zq[e];
         next_pending[e]   = pending[e] | fifoPush[e];
         next_sentStall[e] = sentStall[e];
         next_underrun[e]  = underrun[e];
         next_toggle[e]    = toggle[e];
         next_irq[e]       = done[e] | stallEvt[e];
         if (fwLowWr && fwIndex == e) begin
            // Firmware can only clear these three flags.
            if (!fwWrData[`UIE_LOW_SENT_STALL]) next_sentStall[e] = 1'b0;
            if (!fwWrData[`UIE_LOW_UNDERRUN]) next_underrun[e] = 1'b0;
            if (fwWrData[`UIE_LOW_CLR_TOGGLE]) next_toggle[e] = 1'b0;
         end
         if (done[e]) begin
            next_pktCnt[e] = pktCnt[e] - 2'h1;
            next_zq[e]     = {1'b0, zq[e][1]};
            if (!iso[e] && (forceTgl[e] || hostAck)) begin
               next_toggle[e] = ~toggle[e];
            end
         end
         if (commit[e] && next_pktCnt[e] < slotsOf(dbuf[e])) begin
            pos                 = next_pktCnt[e];
            next_zq[e][pos[0]]  = !pending[e];
            next_pktCnt[e]      = next_pktCnt[e] + 2'h1;
            next_pending[e]     = 1'b0;
            if (isoUpdate && iso[e]) begin
               next_held[e] = held[e] + 2'h1;
            end
         end
         if (sof) begin
            next_held[e] = 2'h0;
         end
         if (flush[e]) begin
            next_irq[e]     = next_irq[e] | (pktCnt[e] != 2'h0) | fifoOutValid[e] | pending[e];
            next_pktCnt[e]  = 2'h0;
            next_held[e]    = 2'h0;
            next_zq[e]      = 2'h0;
            next_pending[e] = 1'b0;
         end
         // Hardware events are applied last so they win over a firmware clear.
         if (stallEvt[e]) next_sentStall[e] = 1'b1;
         if (underEvt[e]) next_underrun[e] = 1'b1;
         // Ready reads as one only while every slot is taken, so a double
         // buffered first load clears it without an interrupt.
         next_pktReady[e] = (next_pktCnt[e] >= slotsOf(dbuf[e]));
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (r = 1; r <= 3; r = r + 1) begin
            pktCnt[r] <= 2'h0;
            held[r]   <= 2'h0;
            zq[r]     <= 2'h0;
         end
         pktReady  <= 3'b000;
         sendStall <= 3'b000;
         sentStall <= 3'b000;
         underrun  <= 3'b000;
         toggle    <= 3'b000;
         pending   <= 3'b000;
         dbuf      <= 3'b000;
         iso       <= 3'b000;
         direction_select    <= 3'b000;
         forceTgl  <= 3'b000;
         split     <= 3'b000;
         epInIrq   <= 3'b000;
      end else begin
         for (r = 1; r <= 3; r = r + 1) begin
            pktCnt[r] <= next_pktCnt[r];
            held[r]   <= next_held[r];
            zq[r]     <= next_zq[r];
            if (fwLowWr && fwIndex == r) begin
               sendStall[r] <= fwWrData[`UIE_LOW_SEND_STALL];
            end
            if (fwHighWr && fwIndex == r) begin
               dbuf[r]     <= fwWrData[`UIE_HIGH_DBUF];
               iso[r]      <= fwWrData[`UIE_HIGH_ISO];
               direction_select[r]   <= fwWrData[`UIE_HIGH_DIR_SEL];
               forceTgl[r] <= fwWrData[`UIE_HIGH_FORCE_TGL];
               split[r]    <= fwWrData[`UIE_HIGH_SPLIT];
            end
         end
         pktReady  <= next_pktReady;
         sentStall <= next_sentStall;
         underrun  <= next_underrun;
         toggle    <= next_toggle;
         pending   <= next_pending;
         epInIrq   <= next_irq;
      end
   end

   // Token answer sequencer; one token is served at a time.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= S_IDLE;
         curEp     <= 2'h1;
         txStart   <= 1'b0;
         txZeroLen <= 1'b0;
         txStall   <= 1'b0;
         txNak     <= 1'b0;
         txToggle  <= 1'b0;
      end else begin
         txStart   <= 1'b0;
         txZeroLen <= 1'b0;
         txStall   <= 1'b0;
         txNak     <= 1'b0;
         case (state)
            S_IDLE: begin
               if (tokOk) begin
                  curEp    <= tokenEp;
                  txToggle <= toggle[tokenEp];
                  if (sendStall[tokenEp] && !iso[tokenEp]) begin
                     txStall <= 1'b1;
                  end else if (avail) begin
                     txStart   <= 1'b1;
                     txZeroLen <= zq[tokenEp][0];
                     state     <= zq[tokenEp][0] ? S_HS : S_SEND;
                  end else if (iso[tokenEp]) begin
                     txStart   <= 1'b1;
                     txZeroLen <= 1'b1;
                  end else begin
                     txNak <= 1'b1;
                  end
               end
            end
            S_SEND: begin
               if (txValid && txReady && txLast) begin
                  state <= S_HS;
               end
            end
            S_HS: begin
               if (iso[curEp] || hostAck || hostTimeout) begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: verification/uie_in_ctrl_asserts.sv */
// Port checker for the IN endpoint control block.
// Assumes one clock domain and an active high asynchronous reset.
`timescale 1ns/1ps
module uie_in_ctrl_asserts (
   input logic       clk,
   input logic       rst,
   input logic [1:0] fwIndex,
   input logic       fwLowWr,
   input logic       fwHighWr,
   input logic [7:0] fwHighRd,
   input logic       tokenIn,
   input logic       hostAck,
   input logic       hostTimeout,
   input logic       txStart,
   input logic       txZeroLen,
   input logic       txStall,
   input logic       txNak,
   input logic       txValid,
   input logic [7:0] txData,
   input logic       txLast,
   input logic       txReady,
   input logic [2:0] epInIrq,
   input logic [2:0] epInEnabled,
   input logic [2:0] epOutEnabled
);
   logic cause;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Every event that may lead to an endpoint interrupt within three cycles.
   // A STALL interrupt comes out together with the STALL answer, so the token itself is a cause.
   assign cause = tokenIn | hostAck | hostTimeout | txStall | txStart | fwLowWr | (txValid & txReady & txLast);
   sequence s_answer;
      txStart || txStall || txNak;
   endsequence
   sequence s_view;
      fwIndex == 2'd1 && $stable(fwIndex) && !$past(fwHighWr);
   endsequence
   sequence s_held;
      ##1 (txValid && $stable(txData) && $stable(txLast));
   endsequence
   chk_one_answer: assert property ($onehot0({txStart, txStall, txNak}))
      else $error("two token answers at once");
   chk_answer_time: assert property (s_answer |-> $past(tokenIn))
      else $error("token answer without token");
   chk_zero_start: assert property (txZeroLen |-> txStart)
      else $error("zero length without start");
   chk_stall_irq: assert property (txStall |-> $onehot(epInIrq))
      else $error("stall without interrupt");
   chk_data_held: assert property (txValid && !txReady && !fwLowWr |-> s_held)
      else $error("stalled byte changed");
   chk_in_enable: assert property (s_view |-> epInEnabled[0] == (fwHighRd[2] | fwHighRd[5]))
      else $error("IN enable differs from mode bits");
   chk_out_enable: assert property (s_view |-> epOutEnabled[0] == (fwHighRd[2] | !fwHighRd[5]))
      else $error("OUT enable differs from mode bits");
   chk_irq_cause: assert property (|epInIrq |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
      else $error("interrupt without cause");
endmodule
bind uie_in_ctrl uie_in_ctrl_asserts i_chk (
   .clk(clk), .rst(rst), .fwIndex(fwIndex), .fwLowWr(fwLowWr), .fwHighWr(fwHighWr),
   .fwHighRd(fwHighRd), .tokenIn(tokenIn), .hostAck(hostAck), .hostTimeout(hostTimeout),
   .txStart(txStart), .txZeroLen(txZeroLen), .txStall(txStall), .txNak(txNak), .txValid(txValid),
   .txData(txData), .txLast(txLast), .txReady(txReady), .epInIrq(epInIrq),
   .epInEnabled(epInEnabled), .epOutEnabled(epOutEnabled)
);

/* File: verification/uie_host_model.sv */
// Host model: sends IN tokens, takes packet bytes, returns a handshake.
// Assumes the bench calls runToken while no other token is in flight.
`timescale 1ns/1ps
module uie_host_model (
   input  logic       clk,
   input  logic       txStart,
   input  logic       txZeroLen,
   input  logic       txStall,
   input  logic       txNak,
   input  logic       txToggle,
   input  logic       txValid,
   input  logic [7:0] txData,
   input  logic       txLast,
   output logic       tokenIn = 1'b0,
   output logic [1:0] tokenEp = 2'd0,
   output logic       hostAck = 1'b0,
   output logic       hostTimeout = 1'b0,
   output logic       txReady = 1'b0
);
   logic [2:0] answer;
   logic       zeroLen;
   logic       toggle;
   logic [7:0] byteCount;
   logic [7:0] lastByte;
   // Slow mode holds off each byte for one cycle; iso pipes get no handshake.
   task automatic runToken(input logic [1:0] ep, input logic iso, input logic tmo, input logic slow);
      int n;
      n = 0;
      byteCount = 8'h00;
      @(posedge clk);
      #1;
      tokenIn = 1'b1;
      tokenEp = ep;
      @(posedge clk);
      #1;
      tokenIn = 1'b0;
      tokenEp = ~ep;
      txReady = !slow;
      @(posedge clk);
      answer = {txStall, txNak, txStart};
      zeroLen = txZeroLen;
      toggle = txToggle;
      while (answer[0] && !zeroLen && n < 40) begin
         if (txValid && txReady) begin
            lastByte = txData;
            byteCount = byteCount + 8'h01;
         end
         n = (txValid && txReady && txLast) ? 40 : n + 1;
         if (n < 40) begin
            #1;
            txReady = slow ? !txReady : 1'b1;
            @(posedge clk);
         end
      end
      #1;
      txReady = 1'b0;
      if (answer[0] && !iso) begin
         hostAck = !tmo;
         hostTimeout = tmo;
         @(posedge clk);
         #1;
         hostAck = 1'b0;
         hostTimeout = 1'b0;
      end
   endtask
endmodule

/* File: verification/uie_in_ctrl_test.sv */
// Self-checking bench for the IN endpoint control block.
// Assumes the host model on the token side and the bound checker.
`timescale 1ns/1ps
module uie_in_ctrl_test;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [1:0] fwIndex = 2'd1;
   logic       fwLowWr = 1'b0;
   logic       fwHighWr = 1'b0;
   logic [7:0] fwWrData = 8'h00;
   logic       fwDataValid = 1'b0;
   logic [7:0] fwData = 8'h00;
   logic       fwDataLast = 1'b0;
   logic       isoUpdate = 1'b0;
   logic       sof = 1'b0;
   logic [7:0] irqHits = 8'h00;
   logic [7:0] base;
   logic [7:0] fwLowRd, fwHighRd, txData;
   logic [2:0] epInIrq, epInEnabled, epOutEnabled;
   logic [1:0] tokenEp;
   logic       fwDataReady, tokenIn, hostAck, hostTimeout, txReady;
   logic       txStart, txZeroLen, txStall, txNak, txToggle, txValid, txLast;
   int         errCount = 0;
   int         checkCount = 0;
   always #10 clk = ~clk;
   always @(posedge clk) if (|epInIrq) irqHits <= irqHits + 8'h01;
   uie_in_ctrl i_dut (
      .clk(clk), .rst(rst), .fwIndex(fwIndex), .fwLowWr(fwLowWr), .fwHighWr(fwHighWr),
      .fwWrData(fwWrData), .fwLowRd(fwLowRd), .fwHighRd(fwHighRd), .fwDataValid(fwDataValid),
      .fwData(fwData), .fwDataLast(fwDataLast), .fwDataReady(fwDataReady), .isoUpdate(isoUpdate),
      .sof(sof), .tokenIn(tokenIn), .tokenEp(tokenEp), .hostAck(hostAck), .hostTimeout(hostTimeout),
      .txStart(txStart), .txZeroLen(txZeroLen), .txStall(txStall), .txNak(txNak), .txToggle(txToggle),
      .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady), .epInIrq(epInIrq),
      .epInEnabled(epInEnabled), .epOutEnabled(epOutEnabled));
   uie_host_model i_host (
      .clk(clk), .txStart(txStart), .txZeroLen(txZeroLen), .txStall(txStall), .txNak(txNak),
      .txToggle(txToggle), .txValid(txValid), .txData(txData), .txLast(txLast), .tokenIn(tokenIn),
      .tokenEp(tokenEp), .hostAck(hostAck), .hostTimeout(hostTimeout), .txReady(txReady));
   task finishTest;
      if (errCount == 0 && checkCount > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checkCount = checkCount + 1;
      if (seen !== exp) begin
         errCount = errCount + 1;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wr(input logic [1:0] idx, input logic high, input logic [7:0] d);
      @(posedge clk);
      #1;
      fwIndex = idx;
      fwLowWr = !high;
      fwHighWr = high;
      fwWrData = d;
      @(posedge clk);
      #1;
      fwLowWr = 1'b0;
      fwHighWr = 1'b0;
   endtask
   task push(input logic [1:0] idx, input logic [7:0] d, input logic last);
      @(posedge clk);
      #1;
      fwIndex = idx;
      fwDataValid = 1'b1;
      fwData = d;
      fwDataLast = last;
      @(posedge clk);
      #1;
      fwDataValid = 1'b0;
   endtask
   task view(input logic [1:0] idx, input logic [7:0] lo, input logic [7:0] hi);
      fwIndex = idx;
      repeat (3) @(posedge clk);
      #1;
      check("low view", fwLowRd, lo);
      check("high view", fwHighRd, hi);
   endtask
   task tok(input logic [1:0] ep, input logic iso, input logic tmo, input logic slow, input logic [2:0] ans);
      i_host.runToken(ep, iso, tmo, slow);
      repeat (3) @(posedge clk);
      #1;
      check("answer", {5'h00, i_host.answer}, {5'h00, ans});
   endtask
   task pkt(input int nb, input logic tmo, input logic tgl);
      for (int i = 0; i < nb; i++) push(2'd1, 8'hA0 + i[7:0], i == nb - 1);
      wr(2'd1, 1'b0, 8'h01);
      tok(2'd1, 1'b0, tmo, nb > 1, 3'b001);
      check("zero length", {7'h00, i_host.zeroLen}, {7'h00, nb == 0});
      check("toggle", {7'h00, i_host.toggle}, {7'h00, tgl});
      check("bytes", i_host.byteCount, nb[7:0]);
   endtask
   task testModes;
      view(2'd1, 8'h00, 8'h00);
      check("out enable", {5'h00, epOutEnabled}, 8'h07);
      wr(2'd1, 1'b1, 8'h20);
      wr(2'd2, 1'b1, 8'h24);
      view(2'd2, 8'h00, 8'h24);
      check("in enable", {5'h00, epInEnabled}, 8'h03);
      check("out enable", {5'h00, epOutEnabled}, 8'h06);
   endtask
   task testBulk;
      base = irqHits;
      pkt(2, 1'b0, 1'b0);
      pkt(0, 1'b1, 1'b1);
      pkt(0, 1'b0, 1'b1);
      wr(2'd1, 1'b1, 8'h28);
      pkt(0, 1'b1, 1'b0);
      pkt(1, 1'b1, 1'b1);
      check("packet irq", irqHits - base, 8'h05);
      view(2'd1, 8'h00, 8'h28);
   endtask
   task testStall;
      base = irqHits;
      wr(2'd1, 1'b0, 8'h10);
      tok(2'd1, 1'b0, 1'b0, 1'b0, 3'b100);
      tok(2'd1, 1'b0, 1'b0, 1'b0, 3'b100);
      check("stall irq", irqHits - base, 8'h02);
      view(2'd1, 8'h30, 8'h28);
      wr(2'd1, 1'b0, 8'h10);
      view(2'd1, 8'h10, 8'h28);
      wr(2'd1, 1'b0, 8'h00);
   endtask
   task testFlush;
      base = irqHits;
      push(2'd1, 8'h5A, 1'b1);
      wr(2'd1, 1'b0, 8'h01);
      wr(2'd1, 1'b0, 8'h08);
      view(2'd1, 8'h00, 8'h28);
      wr(2'd1, 1'b0, 8'h08);
      view(2'd1, 8'h00, 8'h28);
      check("flush irq", irqHits - base, 8'h01);
   endtask
   task testDoubleBuffer;
      wr(2'd1, 1'b1, 8'hA0);
      base = irqHits;
      wr(2'd1, 1'b0, 8'h01);
      view(2'd1, 8'h02, 8'hA0);
      wr(2'd1, 1'b0, 8'h01);
      view(2'd1, 8'h03, 8'hA0);
      check("load irq", irqHits - base, 8'h00);
      tok(2'd1, 1'b0, 1'b0, 1'b0, 3'b001);
      view(2'd1, 8'h02, 8'hA0);
      check("sent irq", irqHits - base, 8'h01);
   endtask
   task testIso;
      wr(2'd3, 1'b1, 8'h60);
      tok(2'd3, 1'b1, 1'b0, 1'b0, 3'b001);
      check("underrun zero", {7'h00, i_host.zeroLen}, 8'h01);
      view(2'd3, 8'h04, 8'h60);
      wr(2'd3, 1'b0, 8'h00);
      isoUpdate = 1'b1;
      push(2'd3, 8'h77, 1'b1);
      wr(2'd3, 1'b0, 8'h01);
      tok(2'd3, 1'b1, 1'b0, 1'b0, 3'b001);
      check("withheld", {7'h00, i_host.zeroLen}, 8'h01);
      sof = 1'b1;
      @(posedge clk);
      #1;
      sof = 1'b0;
      tok(2'd3, 1'b1, 1'b0, 1'b0, 3'b001);
      check("iso byte", i_host.lastByte, 8'h77);
      isoUpdate = 1'b0;
   endtask
   task testFill;
      for (int i = 0; i < 8; i++) push(2'd2, 8'h10 + i[7:0], i == 7);
      check("full", {7'h00, fwDataReady}, 8'h00);
      wr(2'd2, 1'b0, 8'h01);
      tok(2'd2, 1'b0, 1'b0, 1'b1, 3'b001);
      check("drained", i_host.byteCount, 8'h08);
      check("last byte", i_host.lastByte, 8'h17);
      check("free", {7'h00, fwDataReady}, 8'h01);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      testModes();
      testBulk();
      testStall();
      testFlush();
      testDoubleBuffer();
      testIso();
      testFill();
      finishTest();
   end
   // The run needs well under two thousand cycles; this limit only cuts a hang.
   initial begin
      #400000;
      errCount = errCount + 1;
      finishTest();
   end
endmodule
